// >>> hw/eci_defs.svh
// Contract
// - Eight-bit threshold, resets to 08h, 1/2/4 codes
// - Codes 08h-40h give 8 to 64 microframes
// - Light reset bit reads zero if absent
// - Light reset spares ports and companion association
// - Light reset bit reads one until done
// - Evict cached async state, then set flag
// - Enabled flag raises interrupt at threshold boundary
`ifndef ECI_DEFS_SVH
`define ECI_DEFS_SVH
`define ECI_OFS_COMMAND 8'h20
`define ECI_OFS_STATUS 8'h24
`define ECI_OFS_INTR_EN 8'h28
`define ECI_THR_LSB 16
`define ECI_THR_MSB 23
`define ECI_THR_RESET 8'h08
`define ECI_LIGHT_CONTROLLER_RESET_BIT 7
`define ECI_DOORBELL_BIT 6
`define ECI_AAF_BIT 5
`define ECI_HALTED_BIT 12
`define ECI_UFRAME_NS 125000
`define ECI_CLK_NS 5
`define ECI_UFRAME_CYC (`ECI_UFRAME_NS / `ECI_CLK_NS)
`define ECI_LRST_CYC 16
`endif

// >>> hw/eci_pkg.sv
package eci_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } eci_req_t;
    typedef enum logic [1:0] {
        ECI_DB_IDLE = 2'b00,
        ECI_DB_EVICT = 2'b01,
        ECI_DB_WAIT = 2'b10
    } eci_db_state_t;
endpackage : eci_pkg

// >>> hw/eci_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "eci_defs.svh"
module eci_core
    import eci_pkg::*;
#(
    parameter int UFRAME_CYC = `ECI_UFRAME_CYC,
    parameter bit LIGHT_CONTROLLER_RESET_EN = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire eci_req_t req,
    output logic [31:0] rdata,
    input wire logic halted,
    output logic evict_req,
    input wire logic evict_done,
    output logic light_reset,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] thr_reg;
    logic lrst_reg;
    logic [4:0] lrst_cnt_reg;
    logic db_reg;
    logic aaf_reg;
    logic aae_reg;
    eci_db_state_t db_state_reg;
    logic [16:0] uf_cnt_reg;
    logic [6:0] thr_cnt_reg;
    logic pend_reg;
    logic uf_tick;
    logic [6:0] interval;
    logic cmd_wr;
    logic sts_wr;
    logic aaf_set;

    assign cmd_wr = req.wr && req.addr == `ECI_OFS_COMMAND;
    assign sts_wr = req.wr && req.addr == `ECI_OFS_STATUS;
    assign aaf_set = db_state_reg == ECI_DB_WAIT;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            thr_reg <= `ECI_THR_RESET;
        end else if (cmd_wr && !lrst_reg) begin
            thr_reg <= req.wdata[`ECI_THR_MSB:`ECI_THR_LSB];
        end
    end

    // Light reset clears controller state except the threshold; ports live elsewhere.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lrst_reg <= 1'b0;
            lrst_cnt_reg <= 5'h00;
        end else if (lrst_reg) begin
            lrst_cnt_reg <= lrst_cnt_reg + 5'h01;
            if (lrst_cnt_reg == 5'(`ECI_LRST_CYC - 1)) begin
                lrst_reg <= 1'b0;
            end
        end else if (LIGHT_CONTROLLER_RESET_EN && cmd_wr && req.wdata[`ECI_LIGHT_CONTROLLER_RESET_BIT]) begin
            lrst_reg <= 1'b1;
            lrst_cnt_reg <= 5'h00;
        end
    end

    // ------------------------------------------------------------
    // Doorbell
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg) begin
            db_state_reg <= ECI_DB_IDLE;
            db_reg <= 1'b0;
        end else begin
            unique case (db_state_reg)
                ECI_DB_IDLE: begin
                    if (cmd_wr && req.wdata[`ECI_DOORBELL_BIT]) begin
                        db_state_reg <= ECI_DB_EVICT;
                        db_reg <= 1'b1;
                    end
                end
                ECI_DB_EVICT: begin
                    if (evict_done) begin
                        db_state_reg <= ECI_DB_WAIT;
                    end
                end
                ECI_DB_WAIT: begin
                    db_state_reg <= ECI_DB_IDLE;
                    db_reg <= 1'b0;
                end
                default: db_state_reg <= ECI_DB_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            evict_req <= 1'b0;
        end else begin
            evict_req <= db_state_reg == ECI_DB_EVICT && !evict_done && !lrst_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg) begin
            aaf_reg <= 1'b0;
        end else if (aaf_set) begin
            aaf_reg <= 1'b1;
        end else if (sts_wr && req.wdata[`ECI_AAF_BIT]) begin
            aaf_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg) begin
            aae_reg <= 1'b0;
        end else if (req.wr && req.addr == `ECI_OFS_INTR_EN) begin
            aae_reg <= req.wdata[`ECI_AAF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Threshold pacing
    // ------------------------------------------------------------
    always_comb begin
        unique case (thr_reg)
            8'h01: interval = 7'h01;
            8'h02: interval = 7'h02;
            8'h04: interval = 7'h04;
            8'h10: interval = 7'h10;
            8'h20: interval = 7'h20;
            8'h40: interval = 7'h40;
            default: interval = 7'h08;
        endcase
    end

    assign uf_tick = uf_cnt_reg == 17'(UFRAME_CYC - 1);

    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg || uf_tick) begin
            uf_cnt_reg <= 17'h00000;
        end else begin
            uf_cnt_reg <= uf_cnt_reg + 17'h00001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg) begin
            thr_cnt_reg <= 7'h00;
            irq <= 1'b0;
        end else begin
            irq <= 1'b0;
            if (uf_tick) begin
                if (thr_cnt_reg >= interval - 7'h01) begin
                    thr_cnt_reg <= 7'h00;
                    irq <= pend_reg || (aaf_reg && aae_reg);
                end else begin
                    thr_cnt_reg <= thr_cnt_reg + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || lrst_reg) begin
            pend_reg <= 1'b0;
        end else if (aaf_set && aae_reg) begin
            pend_reg <= 1'b1;
        end else if (uf_tick && thr_cnt_reg >= interval - 7'h01) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            light_reset <= 1'b0;
        end else begin
            light_reset <= lrst_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else if (req.rd) begin
            rdata <= 32'h00000000;
            unique case (req.addr)
                `ECI_OFS_COMMAND: begin
                    rdata[`ECI_THR_MSB:`ECI_THR_LSB] <= thr_reg;
                    rdata[`ECI_LIGHT_CONTROLLER_RESET_BIT] <= LIGHT_CONTROLLER_RESET_EN && lrst_reg;
                    rdata[`ECI_DOORBELL_BIT] <= db_reg;
                end
                `ECI_OFS_STATUS: begin
                    rdata[`ECI_AAF_BIT] <= aaf_reg;
                    rdata[`ECI_HALTED_BIT] <= halted;
                end
                `ECI_OFS_INTR_EN: rdata[`ECI_AAF_BIT] <= aae_reg;
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ring;
        db_state_reg == ECI_DB_EVICT && evict_done && !lrst_reg;
    endsequence

    chk_flag_after_evict: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_ring ##1 !lrst_reg |=> aaf_reg)
        else $error("flag not set after eviction");
    chk_thr_reset: assert property (@(posedge ref_clk)
        !resetn |=> thr_reg == 8'h08)
        else $error("threshold reset value wrong");
    chk_irq_boundary: assert property (@(posedge ref_clk) disable iff (!resetn)
        irq |-> $past(uf_tick))
        else $error("interrupt off boundary");
    chk_lrst_read: assert property (@(posedge ref_clk) disable iff (!resetn)
        req.rd && req.addr == `ECI_OFS_COMMAND |=>
        rdata[`ECI_LIGHT_CONTROLLER_RESET_BIT] == (LIGHT_CONTROLLER_RESET_EN && $past(lrst_reg)))
        else $error("light reset read wrong");
    chk_lrst_done: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(lrst_reg) |-> ##[1:17] !lrst_reg)
        else $error("light reset never ends");
    chk_lrst_absent: assert property (@(posedge ref_clk) disable iff (!resetn)
        !LIGHT_CONTROLLER_RESET_EN |-> !lrst_reg)
        else $error("absent light reset active");
    chk_pend_fire: assert property (@(posedge ref_clk) disable iff (!resetn || lrst_reg)
        pend_reg && uf_tick && thr_cnt_reg >= interval - 7'h01 |=> irq)
        else $error("pending event not fired");
    chk_no_early_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pend_reg && !(aaf_reg && aae_reg) |=> !irq)
        else $error("spurious interrupt");
    chk_interval_map: assert property (@(posedge ref_clk) disable iff (!resetn)
        thr_reg == 8'h40 |-> interval == 7'h40)
        else $error("interval decode wrong");
endmodule : eci_core
`default_nettype wire

// >>> verif/eci_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eci_defs.svh"
module testbench;
    import eci_pkg::*;
    localparam int UF = 10;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    eci_req_t req = '0;
    logic halted = 1'b1;
    logic evict_done = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic evict_req;
    logic light_reset;
    logic irq;
    logic [31:0] rdata_nolr;
    logic light_reset_nolr;
    int fails = 0;
    int n_tests = 0;
    int i;
    logic [7:0] codes [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    always #2.5 ref_clk = ~ref_clk;
    eci_core #(.UFRAME_CYC(UF), .LIGHT_CONTROLLER_RESET_EN(1'b1)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata),
        .halted(halted), .evict_req(evict_req), .evict_done(evict_done),
        .light_reset(light_reset), .irq(irq));
    // A second copy without the light reset option shares all stimulus.
    eci_core #(.UFRAME_CYC(UF), .LIGHT_CONTROLLER_RESET_EN(1'b0)) u_dut_nolr (
        .ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata_nolr),
        .halted(halted), .evict_req(), .evict_done(evict_done),
        .light_reset(light_reset_nolr), .irq());
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        req <= '0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        req <= '0;
        #1 d = rdata;
    endtask : rd
    // Rings the doorbell, finishes eviction and measures the delay to the interrupt.
    task ring(input logic [7:0] thr, input logic en);
        // Bit 6 rings the doorbell; bit 5 is also written, but eci_core ignores it in the command register.
        wr(8'h20, {8'h00, thr, 16'h0060});
        for (i = 0; i < 10 && evict_req !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (evict_req !== 1'b1) begin fails++; finish_test(); end
        rd(8'h24);
        chk(d & 32'h1020, 32'h1000);
        @(posedge ref_clk);
        evict_done <= 1'b1;
        @(posedge ref_clk);
        evict_done <= 1'b0;
        for (i = 0; i < int'(thr) * UF + 6; i++) begin
            @(posedge ref_clk);
            #1;
            if (irq === 1'b1) break;
        end
        chk({31'h0, i < int'(thr) * UF + 6}, {31'h0, en});
        if (en && i >= int'(thr) * UF + 6) finish_test();
        // With the flag left set, interrupts repeat once per threshold interval.
        if (en) begin
            for (i = 1; i <= int'(thr) * UF + 2; i++) begin
                @(posedge ref_clk);
                #1;
                if (irq === 1'b1) break;
            end
            chk(i, int'(thr) * UF);
        end
        rd(8'h24);
        chk(d & 32'h1020, 32'h1020);
        wr(8'h24, 32'h20);
        rd(8'h24);
        chk(d & 32'h0020, 32'h0);
        rd(8'h20);
        chk(d & 32'hffff00c0, {8'h00, thr, 16'h0});
    endtask : ring
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(8'h20);
        chk(d, {8'h00, 8'h08, 16'h0});
        rd(8'h30);
        chk(d, 32'h0);
        rd(8'h28);
        chk(d & 32'h20, 32'h0);
        wr(8'h28, 32'h20);
        rd(8'h28);
        chk(d & 32'h20, 32'h20);
        foreach (codes[k]) ring(codes[k], 1'b1);
        wr(8'h28, 32'h0);
        ring(8'h01, 1'b0);
        wr(8'h20, {8'h00, 8'h04, 16'h0080});
        rd(8'h20);
        chk(d & 32'h80, 32'h80);
        chk({31'h0, light_reset}, 32'h1);
        chk(rdata_nolr, {8'h00, 8'h04, 16'h0});
        chk({31'h0, light_reset_nolr}, 32'h0);
        repeat (20) @(posedge ref_clk);
        rd(8'h20);
        chk(d, {8'h00, 8'h04, 16'h0});
        chk({31'h0, light_reset}, 32'h0);
        chk(rdata_nolr, {8'h00, 8'h04, 16'h0});
        @(posedge ref_clk);
        halted <= 1'b0;
        rd(8'h24);
        chk(d & 32'h1000, 32'h0);
        finish_test();
    end
    initial begin
        #200000;
        fails++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
